// file: src/iocbt_block_ctl.sv
// block transfer controller: counters, init sequence, per-word handshake
`timescale 1ns/1ns
`default_nettype none
module iocbt_block_ctl #(
  parameter int LEN_W = 13
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // machine cycle pulse
  input wire logic cycEn,
  // unit side
  input wire logic xferStart,
  input wire logic unitReady,
  output logic unitConnect,
  // dedicated locations
  input wire logic [14:0] cwaLoc,
  input wire logic [14:0] lenLoc,
  input wire logic toMemory,
  // memory request
  iocbt_mem_if.ctl mem,
  // state
  output logic [14:0] currentWordAddress,
  output logic [LEN_W-1:0] blockLengthCount,
  output logic terminateLatch,
  output logic blockDone,
  output logic active
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_LDA = 5'b00010, S_LDL = 5'b00100, S_WAIT = 5'b01000, S_XFER = 5'b10000
  } iocbt_bs_t;
  iocbt_bs_t state;
  logic reinit;
  // sequencer; grant only ends a stolen cycle, so a transfer in progress is never cut
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      currentWordAddress <= '0;
      blockLengthCount <= '0;
      terminateLatch <= 1'b0;
      unitConnect <= 1'b0;
      blockDone <= 1'b0;
      reinit <= 1'b0;
    end else begin
      blockDone <= 1'b0;
      unitConnect <= 1'b0; // a pulse: high only in the clock after the grant
      unique case (state)
        S_IDLE: if (xferStart) state <= S_LDA;
        S_LDA: if (mem.grant) begin
          currentWordAddress <= mem.rdata[14:0];
          state <= S_LDL;
        end
        S_LDL: if (mem.grant) begin
          blockLengthCount <= mem.rdata[LEN_W-1:0];
          terminateLatch <= mem.rdata[iocbt_pkg::STOP_BIT];
          blockDone <= reinit;
          reinit <= 1'b0;
          state <= S_WAIT;
        end
        S_WAIT: if (xferStart) state <= S_LDA;
          else if (unitReady && !unitConnect && blockLengthCount != '0) begin // ready under the connect pulse is spent
            state <= S_XFER;
          end
        S_XFER: begin
          unitConnect <= mem.grant;
          if (mem.grant) begin
            currentWordAddress <= currentWordAddress + 15'h0001;
            blockLengthCount <= blockLengthCount - 1'b1;
            if (blockLengthCount == {{(LEN_W-1){1'b0}}, 1'b1}) begin
              if (terminateLatch) begin
                blockDone <= 1'b1;
                state <= S_IDLE;
              end else begin
                reinit <= 1'b1;
                state <= S_LDA;
              end
            end else state <= S_WAIT;
          end
        end
      endcase
    end
  end
  // address mux onto the stolen memory cycle, one word per cycle
  always_comb begin
    mem.req = (state == S_LDA) || (state == S_LDL) || (state == S_XFER);
    mem.write = (state == S_XFER) && toMemory;
    unique case (state)
      S_LDA: mem.addr = cwaLoc;
      S_LDL: mem.addr = lenLoc;
      default: mem.addr = currentWordAddress;
    endcase
  end
  assign active = (state != S_IDLE);
endmodule : iocbt_block_ctl
`default_nettype wire

// file: src/iocbt_mem_if.sv
// memory cycle request channel between the block controller and the top
`timescale 1ns/1ns
`default_nettype none
interface iocbt_mem_if;
  logic req;
  logic grant;
  logic [14:0] addr;
  logic write;
  logic [23:0] rdata;
  modport ctl (output req, output addr, output write, input grant, input rdata);
  modport arb (input req, input addr, input write, output grant, output rdata);
endinterface : iocbt_mem_if
`default_nettype wire

// file: src/iocbt_pkg.sv
// shared constants, types and register map for the i/o channel and block controller
package iocbt_pkg;
  // machine cycle 1.75 us at 50 MHz
  localparam int SYS_CLK_HZ = 50000000;
  localparam int MACHINE_CYCLE_NS = 1750;
  localparam int CYCLE_CLKS = (MACHINE_CYCLE_NS * (SYS_CLK_HZ / 1000000)) / 1000;
  localparam int WORD_W = 24;
  localparam int UNIT_ADDR_W = 6;
  localparam int LEN_W = 13;
  localparam int ADDR_W = 15;
  localparam logic [LEN_W-1:0] MAX_BLOCK_WORDS = 13'h1FFF;
  // length word: low 13 bits count, bit 23 stop code
  localparam int STOP_BIT = 23;
  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_BTC_CFG = 8'h10;
  localparam logic [7:0] REG_BTC_STAT = 8'h14;
  localparam logic [7:0] REG_BTC_CWA = 8'h18;
  localparam logic [7:0] REG_BTC_LEN = 8'h1C;
  // command register fields
  localparam int CMD_UNIT_LSB = 0;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_WAIT_BIT = 12;
  localparam int CMD_GO_BIT = 31;
  // reset values
  localparam logic [ADDR_W-1:0] CWA_LOC_RST = 15'h0020;
  localparam logic [ADDR_W-1:0] LEN_LOC_RST = 15'h0021;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    OP_MEM_OUT = 3'h0, OP_ACC_OUT = 3'h1, OP_MEM_IN = 3'h2,
    OP_ACC_IN = 3'h3, OP_CMD = 3'h4, OP_TEST = 3'h5
  } iocbt_op_t;
  // output direction bit of the unit code
  function automatic logic iocbt_is_output(input logic [2:0] op);
    return (op == OP_MEM_OUT) || (op == OP_ACC_OUT) || (op == OP_CMD) || (op == OP_TEST);
  endfunction : iocbt_is_output
endpackage : iocbt_pkg

// file: src/iocbt_top.sv
// i/o channel sequencer with block transfer controller and axi4-lite registers
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module iocbt_top #(
  parameter int CYCLE_CLKS = iocbt_pkg::CYCLE_CLKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // i/o cable to units
  output logic [6:0] unitCode,
  output logic dataSyncLine,
  output logic commandSyncLine,
  output logic testSyncLine,
  output logic [23:0] ioDataOut,
  input wire logic [23:0] ioDataIn,
  input wire logic syncReturn,
  input wire logic testReturn,
  // block controller unit lines
  input wire logic transferStart,
  input wire logic unitReadyLine,
  output logic unitConnectLine,
  output logic blockInterrupt,
  // memory port, controller has priority
  input wire logic cpuMemReq,
  output logic cpuMemGrant,
  output logic memReq,
  output logic [14:0] memAddr,
  output logic memWrite,
  output logic [23:0] memWdata,
  input wire logic [23:0] memRdata
);
  typedef enum logic [5:0] {
    C_IDLE = 6'b000001, C_CODE = 6'b000010, C_SEL = 6'b000100,
    C_READY = 6'b001000, C_XFER = 6'b010000, C_DONE = 6'b100000
  } iocbt_ch_t;
  iocbt_ch_t chState;
  // machine cycle divider, every wait is a whole number of these
  logic [$clog2(CYCLE_CLKS)-1:0] divCnt;
  logic cycEn;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cycEn) divCnt <= '0;
    else divCnt <= divCnt + 1'b1;
  end
  assign cycEn = (divCnt == ($clog2(CYCLE_CLKS))'(CYCLE_CLKS - 1));

  // software registers
  logic [31:0] cmd_reg;
  logic [23:0] wdata_reg, rdata_reg, acc_reg;
  logic [14:0] cwaLoc_reg, lenLoc_reg;
  logic toMem_reg;
  logic goPending, chBusy, skipFlag, statusFlag, blkIrq_reg, irqEn_reg;
  logic [2:0] curOp;
  logic waitFlag;
  assign curOp = cmd_reg[iocbt_pkg::CMD_OP_LSB +: 3];
  assign waitFlag = cmd_reg[iocbt_pkg::CMD_WAIT_BIT] && (curOp != iocbt_pkg::OP_TEST);

  // block controller and memory priority
  iocbt_mem_if mbus();
  logic [14:0] current_word_address;
  logic [12:0] blen;
  logic termLatch, blkDone, blkActive;
  iocbt_block_ctl #(.LEN_W(13)) u_blk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cycEn(cycEn),
    .xferStart(transferStart), .unitReady(unitReadyLine), .unitConnect(unitConnectLine),
    .cwaLoc(cwaLoc_reg), .lenLoc(lenLoc_reg), .toMemory(toMem_reg), .mem(mbus.ctl),
    .currentWordAddress(current_word_address), .blockLengthCount(blen), .terminateLatch(termLatch),
    .blockDone(blkDone), .active(blkActive)
  );
  // one memory cycle per machine cycle; controller wins, cpu grant waits
  logic cycleOwned;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cycleOwned <= 1'b0;
      cpuMemGrant <= 1'b0;
      memReq <= 1'b0;
      memAddr <= '0;
      memWrite <= 1'b0;
      memWdata <= '0;
    end else begin
      cpuMemGrant <= cycEn && cpuMemReq && !mbus.req;
      memReq <= cycEn && (mbus.req || cpuMemReq);
      if (cycEn && mbus.req) begin
        memAddr <= mbus.addr;
        memWrite <= mbus.write;
        memWdata <= ioDataIn;
      end
      cycleOwned <= cycEn && mbus.req;
    end
  end
  assign mbus.grant = cycleOwned;
  assign mbus.rdata = memRdata;

  // channel sequencer, stepping once per machine cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chState <= C_IDLE;
      unitCode <= '0;
      dataSyncLine <= 1'b0;
      commandSyncLine <= 1'b0;
      testSyncLine <= 1'b0;
      ioDataOut <= '0;
      rdata_reg <= '0;
      acc_reg <= '0;
      chBusy <= 1'b0;
      skipFlag <= 1'b0;
      statusFlag <= 1'b0;
    end else begin
      if (goPending && chState == C_IDLE) chBusy <= 1'b1;
      if (cycEn) begin
        unique case (chState)
          C_IDLE: if (chBusy) begin
            unitCode <= {iocbt_pkg::iocbt_is_output(curOp), cmd_reg[5:0]};
            skipFlag <= 1'b0;
            chState <= C_CODE;
          end
          C_CODE: begin
            dataSyncLine <= (curOp <= iocbt_pkg::OP_ACC_IN);
            commandSyncLine <= (curOp == iocbt_pkg::OP_CMD);
            testSyncLine <= (curOp == iocbt_pkg::OP_TEST);
            chState <= C_SEL;
          end
          C_SEL: if (syncReturn) begin
            if (curOp == iocbt_pkg::OP_TEST) begin
              ioDataOut <= wdata_reg;
              statusFlag <= testReturn;
              chState <= C_DONE;
            end else chState <= C_READY;
          end
          C_READY: if (testReturn) begin
            if (iocbt_pkg::iocbt_is_output(curOp)) ioDataOut <= curOp == iocbt_pkg::OP_ACC_OUT ? acc_reg : wdata_reg;
            skipFlag <= !waitFlag;
            chState <= C_XFER;
          end else if (!waitFlag) chState <= C_DONE;
          C_XFER: begin
            if (curOp == iocbt_pkg::OP_ACC_IN) acc_reg <= ioDataIn;
            if (curOp == iocbt_pkg::OP_MEM_IN) rdata_reg <= ioDataIn;
            chState <= C_DONE;
          end
          C_DONE: begin
            dataSyncLine <= 1'b0;
            commandSyncLine <= 1'b0;
            testSyncLine <= 1'b0;
            if (!syncReturn) begin
              chBusy <= 1'b0;
              chState <= C_IDLE;
            end
          end
        endcase
      end
    end
  end

  // axi4-lite write path: address and data taken in either order
  logic awHeld, wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic doWrite;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= iocbt_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr[1:0] == 2'h0 && awAddr <= iocbt_pkg::REG_BTC_CFG) ?
          iocbt_pkg::AXI_OKAY : iocbt_pkg::AXI_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  // writable registers; command accepted only while the channel is free
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_reg <= '0;
      wdata_reg <= '0;
      goPending <= 1'b0;
      cwaLoc_reg <= iocbt_pkg::CWA_LOC_RST;
      lenLoc_reg <= iocbt_pkg::LEN_LOC_RST;
      toMem_reg <= 1'b0;
      irqEn_reg <= 1'b0;
    end else begin
      if (goPending && chState == C_IDLE) goPending <= 1'b0;
      if (doWrite && wData[iocbt_pkg::CMD_GO_BIT] && awAddr == iocbt_pkg::REG_CMD && !chBusy) begin
        cmd_reg <= wData;
        goPending <= 1'b1;
      end
      if (doWrite && awAddr == iocbt_pkg::REG_WDATA) wdata_reg <= wData[23:0];
      if (doWrite && awAddr == iocbt_pkg::REG_BTC_CFG) begin
        cwaLoc_reg <= wData[14:0];
        lenLoc_reg <= wData[30:16];
        toMem_reg <= wData[15];
        irqEn_reg <= wData[31];
      end
    end
  end
  // block-done flag: hardware set wins over software clear on status read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) blkIrq_reg <= 1'b0;
    else if (blkDone) blkIrq_reg <= 1'b1;
    else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == iocbt_pkg::REG_BTC_STAT) blkIrq_reg <= 1'b0;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) blockInterrupt <= 1'b0;
    else blockInterrupt <= blkIrq_reg && irqEn_reg;
  end
  // axi4-lite read path, one cycle after acceptance
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= iocbt_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= iocbt_pkg::AXI_OKAY;
        unique case (s_axi_araddr)
          iocbt_pkg::REG_CMD: s_axi_rdata <= cmd_reg;
          iocbt_pkg::REG_WDATA: s_axi_rdata <= {8'h00, wdata_reg};
          iocbt_pkg::REG_STATUS: s_axi_rdata <= {28'h0000000, statusFlag, skipFlag, goPending, chBusy};
          iocbt_pkg::REG_RDATA: s_axi_rdata <= {8'h00, curOp == iocbt_pkg::OP_ACC_IN ? acc_reg : rdata_reg};
          iocbt_pkg::REG_BTC_CFG: s_axi_rdata <= {irqEn_reg, lenLoc_reg, toMem_reg, cwaLoc_reg};
          iocbt_pkg::REG_BTC_STAT: s_axi_rdata <= {29'h00000000, blkIrq_reg, termLatch, blkActive};
          iocbt_pkg::REG_BTC_CWA: s_axi_rdata <= {17'h00000, current_word_address};
          iocbt_pkg::REG_BTC_LEN: s_axi_rdata <= {19'h00000, blen};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= iocbt_pkg::AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end
endmodule : iocbt_top
`default_nettype wire

// file: verification/iocbt_chk.sv
// concurrent checks on the cable and block lines of the top
`timescale 1ns/1ns
`default_nettype none
module iocbt_chk #(
  parameter int CYCLE_CLKS = 87
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // cable
  input wire logic [6:0] unitCode,
  input wire logic dataSyncLine,
  input wire logic commandSyncLine,
  input wire logic testSyncLine,
  input wire logic syncReturn,
  // block lines and memory
  input wire logic transferStart,
  input wire logic unitConnectLine,
  input wire logic memReq,
  input wire logic cpuMemGrant
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] syncs, syncPrev;
  logic seen, started;
  int gap;
  assign syncs = {dataSyncLine, commandSyncLine, testSyncLine};
  // clocks since the last sync edge; the first edge after reset has no base
  always_ff @(posedge sys_clk) begin
    syncPrev <= syncs;
    if (sys_rst || syncs != syncPrev) gap <= 1;
    else gap <= gap + 1;
    if (sys_rst) seen <= 1'b0;
    else if (syncs != syncPrev) seen <= 1'b1;
  end
  // no block activity before the first start
  always_ff @(posedge sys_clk) begin
    if (sys_rst) started <= 1'b0;
    else if (transferStart) started <= 1'b1;
  end
  one_sync_a: assert property ($onehot0(syncs)) else $error("two syncs up");
  code_first_a: assert property ($rose(|syncs) |-> $stable(unitCode)) else $error("code late");
  code_held_a: assert property ($past(|syncs) && |syncs |-> $stable(unitCode)) else $error("code moved");
  dir_bit_a: assert property (commandSyncLine || testSyncLine |-> unitCode[6]) else $error("dir low");
  whole_cyc_a: assert property (seen && syncs != syncPrev |-> gap % CYCLE_CLKS == 0) else $error("part cycle");
  off_line_a: assert property ($rose(|syncs) |-> !syncReturn) else $error("unit on line");
  conn_pulse_a: assert property (unitConnectLine |=> !unitConnectLine) else $error("long connect");
  no_start_a: assert property (!started |-> memReq == cpuMemGrant && !unitConnectLine) else $error("unstarted");
  cpu_yield_a: assert property (unitConnectLine |-> $past(memReq) && !$past(cpuMemGrant)) else $error("cpu won");
endmodule : iocbt_chk
bind iocbt_top iocbt_chk #(.CYCLE_CLKS(CYCLE_CLKS)) chk_u (.*);
`default_nettype wire

// file: verification/iocbt_top_tb_top.sv
// self-checking bench for the i/o channel and block controller
`timescale 1ns/1ns
`default_nettype none
module iocbt_top_tb_top;
  logic sys_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dataSyncLine, commandSyncLine, testSyncLine;
  logic syncReturn, testReturn, transferStart, unitReadyLine, unitConnectLine, blockInterrupt, status;
  logic cpuMemReq, cpuMemGrant, memReq, memWrite, w, ok;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] myAddr, u;
  logic [6:0] unitCode;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rdyDly;
  logic [14:0] memAddr;
  logic [23:0] ioDataOut, ioDataIn, memWdata, memRdata, inWord, d, iw;
  logic [31:0] s_axi_wdata, s_axi_rdata, acc, rdm, s;
  logic [23:0] mem [0:511];
  logic [14:0] reqQ [$];
  int fails, num_checks, k, o;
  int seed = 8;
  int ops [10] = '{3, 1, 0, 2, 4, 5, 5, 2, 2, 4};
  int dlys [10] = '{0, 0, 0, 0, 0, 0, 0, 99, 24, 40};
  iocbt_top #(.CYCLE_CLKS(4)) dut_u (.*, .s_axi_wstrb(4'hF));
  iocbt_unit_model pm_u (.*);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // memory reads straight through, as the controller takes its word on the grant clock; the cpu asks at random
  always @(posedge sys_clk) begin
    cpuMemReq <= 1'($random(seed));
    if (memReq && !cpuMemGrant) begin
      reqQ.push_back(memAddr);
      if (memWrite) mem[memAddr[8:0]] <= memWdata;
    end
  end
  assign memRdata = mem[memAddr[8:0]];
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, 2'h0, s);
    chk(s, exp);
  endtask : rc
  // ready is held until the connect pulse, as a real unit would
  task automatic words(input int n);
    repeat (n) begin
      unitReadyLine <= 1'b1;
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (!unitConnectLine && k < 100);
      chk(32'(unitConnectLine), 32'h1);
      unitReadyLine <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : words
  task automatic start();
    transferStart <= 1'b1;
    @(posedge sys_clk);
    transferStart <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask : start
  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // cut a hang short
  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, transferStart, unitReadyLine} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, inWord, myAddr, rdyDly, status} = '0;
    acc = '0;
    rdm = '0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rc(8'h10, 32'h0021_0020);
    rc(8'h14, 0);
    rc(8'h18, 0);
    rc(8'h1C, 0);
    wr(8'h40, 0, 2'h2);
    rd(8'h40, 2'h2, s);
    chk(s, 0);
    // every op, ready, not ready, wait flag and both status answers
    for (int i = 0; i < 10; i++) begin
      o = ops[i];
      w = i > 7 || i == 6;
      u = 6'($random(seed));
      d = 24'($random(seed));
      iw = 24'($random(seed));
      myAddr <= u;
      inWord <= iw;
      rdyDly <= 8'(dlys[i]);
      status <= i[0];
      wr(8'h04, {8'h0, d}, 2'h0);
      wr(8'h00, {1'b1, 18'h0, w, 1'b0, 3'(o), 2'h0, u}, 2'h0);
      k = 0;
      do begin
        rd(8'h08, 2'h0, s);
        k++;
      end while (s[1:0] != 2'h0 && k < 500);
      chk(32'(s[1:0]), 32'h0);
      ok = o == 5 || w || dlys[i] == 0;
      if (o < 5 && !w) chk(32'(s[2]), 32'(ok));
      if (o == 5) chk(32'(s[3]), 32'(i[0]));
      chk(32'(pm_u.lastCode), {25'h0, o < 2 || o > 3, u});
      chk(32'(pm_u.lastSync), o > 4 ? 1 : o > 3 ? 2 : 4);
      if (ok && o != 2 && o != 3) chk(32'(pm_u.lastData), o == 1 ? acc : {8'h0, d});
      if (ok && o == 3) acc = {8'h0, iw};
      if (ok && o == 2) rdm = {8'h0, iw};
      rc(8'h0C, o == 3 ? acc : rdm);
    end
    // block with stop code: three words then idle
    mem[9'h020] = 24'h000100;
    mem[9'h021] = 24'h800003;
    wr(8'h10, 32'h8021_0020, 2'h0);
    reqQ.delete();
    start();
    words(3);
    chk(32'(reqQ.size()), 5);
    foreach (reqQ[j]) chk(32'(reqQ[j]), j < 2 ? 32'h20 + j : 32'hFE + j);
    chk(32'(blockInterrupt), 1);
    rc(8'h18, 32'h103);
    rc(8'h1C, 0);
    rc(8'h14, 6);
    repeat (2) @(posedge sys_clk);
    chk(32'(blockInterrupt), 0);
    unitReadyLine <= 1'b1;
    k = 0;
    repeat (40) begin
      @(posedge sys_clk);
      k += unitConnectLine;
    end
    unitReadyLine <= 1'b0;
    chk(k + reqQ.size(), 5);
    // block without stop code reloads itself; words now go into memory
    wr(8'h10, 32'h8021_8020, 2'h0);
    mem[9'h020] = 24'h000140;
    mem[9'h021] = 24'h000002;
    start();
    words(2);
    repeat (8) @(posedge sys_clk);
    chk(32'(blockInterrupt), 1);
    rc(8'h18, 32'h140);
    rc(8'h1C, 2);
    rd(8'h14, 2'h0, s);
    chk(32'(s[2:1]), 2);
    chk(32'(mem[9'h141]), {8'h00, ~inWord});
    report_and_stop();
  end
endmodule : iocbt_top_tb_top
`default_nettype wire

// file: verification/iocbt_unit_model.sv
// behavioural peripheral unit on the i/o cable
`timescale 1ns/1ns
`default_nettype none
module iocbt_unit_model (
  // clock
  input wire logic sys_clk,
  // cable from the computer
  input wire logic [6:0] unitCode,
  input wire logic dataSyncLine,
  input wire logic commandSyncLine,
  input wire logic testSyncLine,
  input wire logic [23:0] ioDataOut,
  // answers to the computer
  output logic syncReturn,
  output logic testReturn,
  output logic [23:0] ioDataIn,
  // behaviour set by the bench
  input wire logic [5:0] myAddr,
  input wire logic [7:0] rdyDly,
  input wire logic status,
  input wire logic [23:0] inWord
);
  logic [2:0] syncs, lastSync;
  logic [6:0] lastCode;
  logic [23:0] lastData;
  logic hit;
  int n = 0;
  int hold = 0;
  assign syncs = {dataSyncLine, commandSyncLine, testSyncLine};
  // data reach every unit, so only our own code is taken
  assign hit = (|syncs) && unitCode[5:0] == myAddr;
  // released data lines show the inverse, not the last word
  assign ioDataIn = hit ? inWord : ~inWord;
  // slow unit: answers a clock late, stays on line 6 clocks after sync drops
  always @(posedge sys_clk) begin
    n <= hit ? n + 1 : 0;
    hold <= hit ? 6 : (hold > 0 ? hold - 1 : 0);
    syncReturn <= (hit && n >= 1) || (!hit && hold > 1);
    testReturn <= hit && (testSyncLine ? status : n >= rdyDly);
    if (hit) begin
      lastCode <= unitCode;
      lastSync <= syncs;
      lastData <= ioDataOut;
    end
  end
endmodule : iocbt_unit_model
`default_nettype wire
